// ==== pkg/efiu_regs.svh ====
/*
  Register offsets, field positions, reset values and timing counts of the
  event flag and interrupt unit.
  Assumes a 125 MHz core clock and a 32-bit APB with byte addresses.
*/
`ifndef EFIU_REGS_SVH
`define EFIU_REGS_SVH

`define EFIU_CLK_MHZ 125
// byte offsets on the register bus
`define EFIU_OFS_EVT_STAT_A 8'h00
`define EFIU_OFS_WAKE_STAT 8'h04
`define EFIU_OFS_IRQ_MASK 8'h08
`define EFIU_OFS_LIVE_STATE 8'h0C
`define EFIU_OFS_WAKE_SRC 8'h10
`define EFIU_OFS_MODE_WD 8'h14
// event_status_reg_a fields; mask bits share positions 0..10
`define EFIU_A_CAN_TO 0
`define EFIU_A_LIN1_TO 1
`define EFIU_A_LIN2_TO 2
`define EFIU_A_BUCK_UNREG 3
`define EFIU_A_BUCK_OL 4
`define EFIU_A_BOOST_ACT 5
`define EFIU_A_BOOST_OL 6
`define EFIU_A_TWAR 7
`define EFIU_A_WD_MISS 8
`define EFIU_A_AUX_UV 9
`define EFIU_A_AUX_OV 10
`define EFIU_A_SPI_FAIL 11
// wake_status_reg wake fields; wake_source_ctrl_reg wake enables at 0..3 only, timer enable in mode_watchdog_ctrl_reg
`define EFIU_W_LOCAL 0
`define EFIU_W_CAN 1
`define EFIU_W_LIN1 2
`define EFIU_W_LIN2 3
`define EFIU_W_TIMER 4
// wake_source_ctrl_reg timeout enables, mode_watchdog_ctrl_reg timer enable
`define EFIU_C_LIN1_TO_EN 4
`define EFIU_C_LIN2_TO_EN 5
`define EFIU_M_TIMER_EN 0
// reset values
`define EFIU_RST_MASK 11'h000
`define EFIU_RST_WAKE_SRC 6'h00
`define EFIU_RST_MODE_WD 1'h0
// synchroniser reset: irq line, csn and transmit inputs idle high, sck and live states low
`define EFIU_RST_SYNC 13'h1B80
// serial frame lengths that are legal
`define EFIU_SPI_CLKS_OK 5'h10
// timing: least times, rounded up to whole cycles
`define EFIU_IRQ_LOW_NS 100000
`define EFIU_IRQ_GAP_NS 1000000
`define EFIU_TX_TO_NS 1000000
`define EFIU_IRQ_LOW_CYC ((`EFIU_IRQ_LOW_NS * `EFIU_CLK_MHZ + 999) / 1000)
`define EFIU_IRQ_GAP_CYC ((`EFIU_IRQ_GAP_NS * `EFIU_CLK_MHZ + 999) / 1000)
`define EFIU_TX_TO_CYC ((`EFIU_TX_TO_NS * `EFIU_CLK_MHZ + 999) / 1000)

`endif

// ==== pkg/efiu_pkg.sv ====
/*
  Types of the event flag and interrupt unit.
  Assumes the mode controller drives the operating mode as efiu_mode_e.
*/
package efiu_pkg;
  typedef enum logic [2:0] {
    EFIU_MODE_STARTUP,
    EFIU_MODE_NORMAL,
    EFIU_MODE_STANDBY,
    EFIU_MODE_FLASH,
    EFIU_MODE_SLEEP,
    EFIU_MODE_RESET,
    EFIU_MODE_OTHER
  } efiu_mode_e;

  typedef enum logic [1:0] {
    EFIU_IRQ_IDLE,
    EFIU_IRQ_LOW,
    EFIU_IRQ_GAP
  } efiu_irq_e;

  // live analog states, asynchronous to ref_clk
  typedef struct packed {
    logic aux_supply_overvolt_state;
    logic aux_supply_undervolt_state;
    logic thermal_warning_state;
    logic boost_overload_state;
    logic boost_active_state;
    logic buck_overload_state;
    logic buck_unregulated_state;
  } efiu_live_s;

  // wake detections, one-cycle pulses from same-clock logic
  typedef struct packed {
    logic timer;
    logic lin2;
    logic lin1;
    logic can;
    logic local_wake;
  } efiu_wake_s;

  typedef struct packed {
    logic [7:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } efiu_apb_req_s;
endpackage

// ==== verilog/efiu_top.sv ====
/*
  Event flag and interrupt request unit: latches events into flags read and
  cleared over APB, masks them and pulses an open-drain request line.
  Assumes the mode controller, watchdog and wake detectors run on ref_clk;
  live states, transmit inputs and serial pins are asynchronous.
*/
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "efiu_regs.svh"

// Overview of operation
// - request line open-drain, active low, idle high
// - pulses only in startup, normal, standby, flash
// - bus and local wakes always request
// - standby timer wake always requests
// - flag always sets; low mask blocks request
// - flags hold until read-and-clear
// - unmasked event drives line low one pulse
// - pending or new events repeat after gap
// - watchdog miss pulses once per miss
// - flags kept across mode transitions
// - standby entry with pending repeats pulse
// - sleep with wake flag aborts sleep
// - reset mode clears non-wake flags, masks all
// - transmit held low too long sets timeout
// - timeout flag survives clear while persisting
// - converter state changes set converter flags
// - thermal warning crossing sets warning flag
// - undervolt only while on; overvolt always
// - bad clock count or edge sets frame error
// - wake flags need enabled source
// - live states readable after flag clears
// - lin timeout detection has serial enable
module efiu_top
  import efiu_pkg::*;
#(
  parameter logic [19:0] IRQ_LOW_CYC = 20'(`EFIU_IRQ_LOW_CYC),
  parameter logic [19:0] IRQ_GAP_CYC = 20'(`EFIU_IRQ_GAP_CYC),
  parameter logic [19:0] TX_TO_CYC = 20'(`EFIU_TX_TO_CYC)
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // apb slave
  input wire efiu_pkg::efiu_apb_req_s apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // device state, same clock
  input wire efiu_pkg::efiu_mode_e op_mode,
  input wire logic sw_dev_cfg,
  input wire logic aux_supply_on,
  input wire logic wd_miss_evt,
  input wire efiu_pkg::efiu_wake_s wake_evt,
  input wire logic sleep_req,
  input wire logic [2:0] xcvr_normal,
  output logic sleep_abort,
  // asynchronous inputs
  input wire efiu_pkg::efiu_live_s live_in,
  input wire logic [2:0] transceiver_tx_input,
  input wire logic spi_sck,
  input wire logic spi_csn,
  // open-drain request line
  input wire logic irq_out_n_i,
  output logic irq_out_n_o,
  output logic irq_out_n_oe
);
  import efiu_pkg::*;

  localparam int NSYNC = 13;
  // stages start at each pin's idle level so release of reset is no edge
  localparam logic [NSYNC-1:0] SYNC_RST = `EFIU_RST_SYNC;

  logic [NSYNC-1:0] async_in;
  logic [NSYNC-1:0] sync1, sync2, sync3;
  logic [NSYNC-1:0] stable, stable_d;
  logic [6:0] live_now, live_edge;
  logic [2:0] tx_low, to_active, to_en;
  logic sck_s, csn_s, csn_d;
  logic [4:0] sck_cnt;
  logic spi_fail_set;
  logic [11:0] flags_a;
  logic [4:0] flags_w;
  logic [11:0] set_a;
  logic [4:0] set_w;
  logic [10:0] irq_mask;
  logic [5:0] wake_src;
  logic mode_wd;
  logic apb_setup, apb_done;
  logic rd_clr_a, rd_clr_w;
  logic in_reset_mode, irq_mode_ok;
  logic new_unmasked, pending, irq_req, irq_start;
  efiu_irq_e irq_state;
  logic [19:0] irq_cnt;

  // three-stage synchronisers; a change counts once stages two and three agree
  assign async_in = {irq_out_n_i, spi_csn, spi_sck, transceiver_tx_input, live_in};

  generate
    for (genvar i = 0; i < NSYNC; i++)
    begin : g_sync
      always_ff @(posedge ref_clk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          sync1[i] <= SYNC_RST[i];
          sync2[i] <= SYNC_RST[i];
          sync3[i] <= SYNC_RST[i];
          stable[i] <= SYNC_RST[i];
          stable_d[i] <= SYNC_RST[i];
        end
        else
        begin
          sync1[i] <= async_in[i];
          sync2[i] <= sync1[i];
          sync3[i] <= sync2[i];
          if (sync2[i] == sync3[i])
          begin
            stable[i] <= sync3[i];
          end
          stable_d[i] <= stable[i];
        end
      end
    end
  endgenerate

  // the first sample after reset is not taken as an edge; pins reset to idle
  assign live_now = stable[6:0];
  assign live_edge = stable[6:0] ^ stable_d[6:0];
  assign tx_low = ~stable[9:7];
  assign sck_s = stable[10];
  assign csn_s = stable[11];

  assign in_reset_mode = (op_mode == EFIU_MODE_RESET);
  assign irq_mode_ok = (op_mode == EFIU_MODE_STARTUP) || (op_mode == EFIU_MODE_NORMAL) ||
    (op_mode == EFIU_MODE_STANDBY) || (op_mode == EFIU_MODE_FLASH);

  // transmit-dominant timeout per transceiver; can has no enable
  assign to_en = {wake_src[`EFIU_C_LIN2_TO_EN], wake_src[`EFIU_C_LIN1_TO_EN], 1'b1};

  generate
    for (genvar t = 0; t < 3; t++)
    begin : g_txto
      logic [19:0] to_cnt;
      always_ff @(posedge ref_clk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          to_cnt <= 20'h00000;
        end
        else if (!tx_low[t] || !xcvr_normal[t] || !to_en[t])
        begin
          to_cnt <= 20'h00000;
        end
        else if (to_cnt != TX_TO_CYC)
        begin
          to_cnt <= to_cnt + 20'h00001;
        end
      end
      // stays high while the long dominant lasts, so a clear cannot stick
      assign to_active[t] = (to_cnt == TX_TO_CYC);
    end
  endgenerate

  // serial frame checker: clocks counted between chip-select edges
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      csn_d <= 1'b1;
      sck_cnt <= 5'h00;
      spi_fail_set <= 1'b0;
    end
    else
    begin
      csn_d <= csn_s;
      spi_fail_set <= 1'b0;
      if (csn_s != csn_d)
      begin
        sck_cnt <= 5'h00;
        if (sck_s || (csn_s && sck_cnt != 5'h00 && sck_cnt != `EFIU_SPI_CLKS_OK))
        begin
          spi_fail_set <= 1'b1;
        end
      end
      else if (!csn_s && sck_s && !stable_d[10] && sck_cnt != 5'h1F)
      begin
        // saturates so an overlong frame never wraps back to a legal count
        sck_cnt <= sck_cnt + 5'h01;
      end
    end
  end

  // event set terms
  always_comb
  begin
    set_a = 12'h000;
    set_a[`EFIU_A_CAN_TO] = to_active[0];
    set_a[`EFIU_A_LIN1_TO] = to_active[1];
    set_a[`EFIU_A_LIN2_TO] = to_active[2];
    set_a[`EFIU_A_BUCK_UNREG] = live_edge[0];
    set_a[`EFIU_A_BUCK_OL] = live_edge[1];
    set_a[`EFIU_A_BOOST_ACT] = live_edge[2];
    set_a[`EFIU_A_BOOST_OL] = live_edge[3];
    set_a[`EFIU_A_TWAR] = live_edge[4];
    set_a[`EFIU_A_WD_MISS] = wd_miss_evt && sw_dev_cfg;
    set_a[`EFIU_A_AUX_UV] = live_edge[5] && aux_supply_on;
    set_a[`EFIU_A_AUX_OV] = live_edge[6];
    set_a[`EFIU_A_SPI_FAIL] = spi_fail_set;
    set_w = 5'h00;
    set_w[`EFIU_W_LOCAL] = wake_evt.local_wake && wake_src[`EFIU_W_LOCAL];
    set_w[`EFIU_W_CAN] = wake_evt.can && wake_src[`EFIU_W_CAN];
    set_w[`EFIU_W_LIN1] = wake_evt.lin1 && wake_src[`EFIU_W_LIN1];
    set_w[`EFIU_W_LIN2] = wake_evt.lin2 && wake_src[`EFIU_W_LIN2];
    set_w[`EFIU_W_TIMER] = wake_evt.timer && mode_wd &&
      (op_mode == EFIU_MODE_STANDBY);
  end

  // apb: one access cycle, no wait states
  assign apb_setup = apb_req.psel && !apb_req.penable;
  assign apb_done = apb_req.psel && apb_req.penable && pready;
  assign rd_clr_a = apb_done && !apb_req.pwrite && (apb_req.paddr == `EFIU_OFS_EVT_STAT_A);
  assign rd_clr_w = apb_done && !apb_req.pwrite && (apb_req.paddr == `EFIU_OFS_WAKE_STAT);

  // status flags; mode transitions other than reset leave them alone
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      flags_a <= 12'h000;
      flags_w <= 5'h00;
    end
    else
    begin
      // wake flags survive reset mode
      flags_w <= (flags_w & ~{5{rd_clr_w}}) | set_w;
      if (in_reset_mode)
      begin
        flags_a <= 12'h000;
      end
      else
      begin
        flags_a <= (flags_a & ~{12{rd_clr_a}}) | set_a;
      end
    end
  end

  // software-written control
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      irq_mask <= `EFIU_RST_MASK;
      wake_src <= `EFIU_RST_WAKE_SRC;
      mode_wd <= `EFIU_RST_MODE_WD;
    end
    else
    begin
      if (in_reset_mode)
      begin
        irq_mask <= `EFIU_RST_MASK;
      end
      else if (apb_done && apb_req.pwrite && apb_req.paddr == `EFIU_OFS_IRQ_MASK)
      begin
        irq_mask <= apb_req.pwdata[10:0];
      end
      if (apb_done && apb_req.pwrite && apb_req.paddr == `EFIU_OFS_WAKE_SRC)
      begin
        wake_src <= apb_req.pwdata[5:0];
      end
      if (apb_done && apb_req.pwrite && apb_req.paddr == `EFIU_OFS_MODE_WD)
      begin
        mode_wd <= apb_req.pwdata[`EFIU_M_TIMER_EN];
      end
    end
  end

  // read data and answer, registered in the setup cycle
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else
    begin
      pready <= apb_setup;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      if (apb_setup)
      begin
        unique case (apb_req.paddr)
          `EFIU_OFS_EVT_STAT_A: prdata <= {20'h00000, flags_a};
          `EFIU_OFS_WAKE_STAT: prdata <= {27'h0000000, flags_w};
          `EFIU_OFS_IRQ_MASK: prdata <= {21'h000000, irq_mask};
          `EFIU_OFS_LIVE_STATE: prdata <= {24'h000000, stable[12], live_now};
          `EFIU_OFS_WAKE_SRC: prdata <= {26'h0000000, wake_src};
          `EFIU_OFS_MODE_WD: prdata <= {31'h00000000, mode_wd};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // request sources; the watchdog miss is left out of the repeat term
  assign new_unmasked = (|(set_a[10:0] & irq_mask)) || (|set_w);
  assign pending = (|(flags_a[10:0] & irq_mask & ~(11'h001 << `EFIU_A_WD_MISS))) ||
    (|flags_w);
  assign irq_start = (irq_state == EFIU_IRQ_IDLE) && irq_mode_ok && (irq_req || pending);

  // events arriving during a pulse or gap are remembered for the next pulse
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      irq_req <= 1'b0;
    end
    else
    begin
      irq_req <= new_unmasked || (irq_req && !irq_start);
    end
  end

  // pulse low, then hold the gap before the next pulse may start
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      irq_state <= EFIU_IRQ_IDLE;
      irq_cnt <= 20'h00000;
      irq_out_n_oe <= 1'b0;
      irq_out_n_o <= 1'b0;
    end
    else
    begin
      // open-drain: only ever pulls low; the pull-up gives the idle high
      irq_out_n_o <= 1'b0;
      unique case (irq_state)
        EFIU_IRQ_IDLE:
        begin
          if (irq_start)
          begin
            irq_state <= EFIU_IRQ_LOW;
            irq_cnt <= 20'h00001;
            irq_out_n_oe <= 1'b1;
          end
        end
        EFIU_IRQ_LOW:
        begin
          // a mode that forbids requests cuts the pulse short
          if (irq_cnt >= IRQ_LOW_CYC || !irq_mode_ok)
          begin
            irq_state <= EFIU_IRQ_GAP;
            irq_cnt <= 20'h00001;
            irq_out_n_oe <= 1'b0;
          end
          else
          begin
            irq_cnt <= irq_cnt + 20'h00001;
          end
        end
        EFIU_IRQ_GAP:
        begin
          if (irq_cnt >= IRQ_GAP_CYC)
          begin
            irq_state <= EFIU_IRQ_IDLE;
            irq_cnt <= 20'h00000;
          end
          else
          begin
            irq_cnt <= irq_cnt + 20'h00001;
          end
        end
      endcase
    end
  end

  // sleep is refused while a wake is still unread
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sleep_abort <= 1'b0;
    end
    else
    begin
      sleep_abort <= sleep_req && (|flags_w);
    end
  end
endmodule
`default_nettype wire

// ==== testbench/efiu_top_sva.sv ====
/* checker on the ports of the event flag unit
   bound to efiu_top; sees its ports only */
`timescale 1ns/1ps
`default_nettype none
module efiu_top_sva
  import efiu_pkg::*;
#(
  parameter logic [19:0] IRQ_LOW_CYC = 20'h4,
  parameter logic [19:0] IRQ_GAP_CYC = 20'h8
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // watched ports
  input wire efiu_pkg::efiu_apb_req_s apb_req,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire efiu_pkg::efiu_mode_e op_mode,
  input wire logic sleep_req,
  input wire logic sleep_abort,
  input wire logic irq_out_n_o,
  input wire logic irq_out_n_oe
);
  logic [19:0] hi_cnt;
  logic [19:0] lo_cnt;
  logic mode_ok;
  assign mode_ok = op_mode inside {EFIU_MODE_STARTUP, EFIU_MODE_NORMAL,
    EFIU_MODE_STANDBY, EFIU_MODE_FLASH};
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      hi_cnt <= 20'h0;
    else if (irq_out_n_oe)
      hi_cnt <= hi_cnt + 20'h1;
    else
      hi_cnt <= 20'h0;
  end
  // starts saturated so the first pulse after reset is not held to the gap
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      lo_cnt <= 20'hFFFFF;
    else if (irq_out_n_oe)
      lo_cnt <= 20'h0;
    else if (lo_cnt != 20'hFFFFF)
      lo_cnt <= lo_cnt + 20'h1;
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);
  sequence s_setup;
    apb_req.psel && !apb_req.penable;
  endsequence
  sequence s_rd(logic [7:0] a);
    pready && !apb_req.pwrite && apb_req.paddr == a;
  endsequence
  AST_OD_LEVEL: assert property (irq_out_n_oe |-> !irq_out_n_o)
    else $error("request line driven high");
  AST_MODE_GATE: assert property ($rose(irq_out_n_oe) |-> $past(mode_ok))
    else $error("request pulse in a quiet mode");
  AST_LOW_TIME: assert property ($fell(irq_out_n_oe) && mode_ok |-> hi_cnt == IRQ_LOW_CYC)
    else $error("request pulse length wrong");
  AST_MIN_GAP: assert property ($rose(irq_out_n_oe) |-> lo_cnt >= IRQ_GAP_CYC)
    else $error("request pulses too close");
  AST_SLEEP_ABORT: assert property (sleep_abort |-> $past(sleep_req) ##1 !sleep_abort)
    else $error("sleep abort without request");
  AST_RST_CLEAR: assert property ((s_rd(8'h00) or s_rd(8'h08))
    ##0 ($past(op_mode, 2) == EFIU_MODE_RESET) |-> prdata == 32'h0)
    else $error("flags or masks kept in reset mode");
  AST_PREADY_NEXT: assert property (s_setup |=> pready ##1 !pready)
    else $error("pready not one cycle after setup");
  AST_ERR_MAP: assert property (pready |-> pslverr ==
    !(apb_req.paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14}))
    else $error("pslverr wrong for address");
endmodule
bind efiu_top efiu_top_sva #(
  .IRQ_LOW_CYC(IRQ_LOW_CYC),
  .IRQ_GAP_CYC(IRQ_GAP_CYC)
) u_sva (
  .ref_clk, .arst_n, .apb_req, .prdata, .pready, .pslverr, .op_mode,
  .sleep_req, .sleep_abort, .irq_out_n_o, .irq_out_n_oe
);
`default_nettype wire

// ==== testbench/efiu_mcu_model.sv ====
/* microcontroller side of the request line: resolves the wire, counts pulses
   assumes a pull-up on the line and sampling on ref_clk */
`timescale 1ns/1ps
`default_nettype none
module efiu_mcu_model
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // request line
  input wire logic irq_out_n_o,
  input wire logic irq_out_n_oe,
  output logic irq_wire,
  output logic [31:0] pulse_cnt
);
  logic last;
  // pull-up holds the line whenever the unit lets go
  assign irq_wire = irq_out_n_oe ? irq_out_n_o : 1'b1;
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      last <= 1'b1;
    else
      last <= irq_wire;
  end
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      pulse_cnt <= 32'h0;
    else if (last && !irq_wire)
      pulse_cnt <= pulse_cnt + 32'h1;
  end
endmodule
`default_nettype wire

// ==== testbench/efiu_top_tb_top.sv ====
/* bench for the event flag unit: registers, flags and request pulses
   assumes the checker binds itself and the model counts pulses */
`timescale 1ns/1ps
`default_nettype none
module efiu_top_tb_top;
  import efiu_pkg::*;
  typedef struct packed {
    logic [7:0] a;
    logic w;
    logic [31:0] d;
    logic [31:0] e;
    logic err;
  } efiu_row_s;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  efiu_apb_req_s req = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  efiu_mode_e op_mode = EFIU_MODE_NORMAL;
  logic sw_dev_cfg = 1'b0;
  logic aux_on = 1'b1;
  logic wd_miss = 1'b0;
  efiu_wake_s wake = '0;
  logic sleep_req = 1'b0;
  logic [2:0] xcvr = 3'h0;
  logic sleep_abort;
  efiu_live_s live = '0;
  logic [2:0] tx_in = 3'h7;
  logic sck = 1'b0;
  logic csn = 1'b1;
  logic irq_wire;
  logic irq_o;
  logic irq_oe;
  logic [31:0] pulse_cnt;
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [31:0] q;
  logic e;
  logic [31:0] c0;
  int fidx [7] = '{3, 4, 5, 6, 7, 9, 10};
  int nclk [3] = '{3, 16, 0};
  efiu_row_s rows [15] = '{
    '{8'h08, 1'b1, 32'h7FF, 32'h0, 1'b0}, '{8'h08, 1'b0, 32'h0, 32'h7FF, 1'b0},
    '{8'h10, 1'b1, 32'h3F, 32'h0, 1'b0}, '{8'h10, 1'b0, 32'h0, 32'h3F, 1'b0},
    '{8'h14, 1'b1, 32'h1, 32'h0, 1'b0}, '{8'h14, 1'b0, 32'h0, 32'h1, 1'b0},
    '{8'h00, 1'b1, 32'hFFF, 32'h0, 1'b0}, '{8'h00, 1'b0, 32'h0, 32'h0, 1'b0},
    '{8'h0C, 1'b1, 32'hFF, 32'h0, 1'b0}, '{8'h0C, 1'b0, 32'h0, 32'h80, 1'b0},
    '{8'h20, 1'b0, 32'h0, 32'h0, 1'b1}, '{8'h24, 1'b1, 32'h5, 32'h0, 1'b1},
    '{8'h08, 1'b1, 32'h0, 32'h0, 1'b0}, '{8'h08, 1'b0, 32'h0, 32'h0, 1'b0},
    '{8'h06, 1'b0, 32'h0, 32'h0, 1'b1}};
  efiu_top #(
    .IRQ_LOW_CYC(20'h4),
    .IRQ_GAP_CYC(20'h8),
    .TX_TO_CYC(20'h10)
  ) u_dut (
    .ref_clk(ref_clk), .arst_n(arst_n), .apb_req(req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .op_mode(op_mode), .sw_dev_cfg(sw_dev_cfg),
    .aux_supply_on(aux_on), .wd_miss_evt(wd_miss), .wake_evt(wake),
    .sleep_req(sleep_req), .xcvr_normal(xcvr), .sleep_abort(sleep_abort),
    .live_in(live), .transceiver_tx_input(tx_in), .spi_sck(sck), .spi_csn(csn),
    .irq_out_n_i(irq_wire), .irq_out_n_o(irq_o), .irq_out_n_oe(irq_oe)
  );
  efiu_mcu_model u_mcu (
    .ref_clk(ref_clk), .arst_n(arst_n), .irq_out_n_o(irq_o),
    .irq_out_n_oe(irq_oe), .irq_wire(irq_wire), .pulse_cnt(pulse_cnt)
  );
  always #4 ref_clk = ~ref_clk;
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // the whole run needs under 2000 cycles
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_count++;
      stop_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    req <= '{a, 1'b1, 1'b0, w, d};
    @(posedge ref_clk);
    req.penable <= 1'b1;
    // no wait-state count is assumed; only the bench timeout ends a hang
    do
    begin
      @(posedge ref_clk);
    end
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    chk("pready", {31'h0, pready}, 32'h1);
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    xfer(a, 1'b0, 32'h0);
    chk($sformatf("rd %h", a), q, x);
  endtask
  task automatic pulse_wake(input efiu_wake_s w);
    wake <= w;
    @(posedge ref_clk);
    wake <= '0;
  endtask
  initial
  begin
    tick(8);
    arst_n <= 1'b1;
    tick(6);
    xfer(8'h00, 1'b0, 32'h0);
    xfer(8'h04, 1'b0, 32'h0);
    foreach (rows[i])
    begin
      xfer(rows[i].a, rows[i].w, rows[i].d);
      if (!rows[i].w)
        chk("row rd", q, rows[i].e);
      chk("row err", {31'h0, e}, {31'h0, rows[i].err});
    end
    // every live state, both edges, all masked
    for (int i = 0; i < 7; i++)
    begin
      c0 = pulse_cnt;
      live[i] <= 1'b1;
      tick(8);
      rd(8'h0C, 32'h80 | (32'h1 << i));
      rd(8'h00, 32'h1 << fidx[i]);
      rd(8'h0C, 32'h80 | (32'h1 << i));
      live[i] <= 1'b0;
      tick(8);
      rd(8'h00, 32'h1 << fidx[i]);
      chk("masked", pulse_cnt, c0);
    end
    aux_on <= 1'b0;
    live[5] <= 1'b1;
    tick(8);
    live[5] <= 1'b0;
    tick(8);
    rd(8'h00, 32'h0);
    aux_on <= 1'b1;
    xfer(8'h08, 1'b1, 32'h8);
    c0 = pulse_cnt;
    live[0] <= 1'b1;
    tick(12);
    chk("pulse", pulse_cnt, c0 + 32'h1);
    rd(8'h00, 32'h8);
    live[0] <= 1'b0;
    tick(8);
    rd(8'h00, 32'h8);
    xfer(8'h08, 1'b1, 32'h0);
    // lin2 timeout left disabled
    xcvr <= 3'h7;
    xfer(8'h10, 1'b1, 32'h1F);
    tx_in <= 3'h0;
    tick(30);
    rd(8'h00, 32'h3);
    rd(8'h00, 32'h3);
    tx_in <= 3'h7;
    tick(8);
    rd(8'h00, 32'h3);
    rd(8'h00, 32'h0);
    sw_dev_cfg <= 1'b1;
    xfer(8'h08, 1'b1, 32'h100);
    c0 = pulse_cnt;
    repeat (2)
    begin
      wd_miss <= 1'b1;
      @(posedge ref_clk);
      wd_miss <= 1'b0;
      tick(40);
    end
    chk("wd pulses", pulse_cnt, c0 + 32'h2);
    rd(8'h00, 32'h100);
    xfer(8'h08, 1'b1, 32'h0);
    foreach (nclk[j])
    begin
      csn <= 1'b0;
      tick(4);
      repeat (nclk[j])
      begin
        sck <= 1'b1;
        tick(4);
        sck <= 1'b0;
        tick(4);
      end
      csn <= 1'b1;
      tick(8);
      rd(8'h00, (nclk[j] == 16 || nclk[j] == 0) ? 32'h0 : 32'h800);
    end
    // clock already high when chip-select falls
    sck <= 1'b1;
    tick(8);
    csn <= 1'b0;
    tick(8);
    sck <= 1'b0;
    tick(8);
    csn <= 1'b1;
    tick(8);
    rd(8'h00, 32'h800);
    op_mode <= EFIU_MODE_SLEEP;
    c0 = pulse_cnt;
    pulse_wake(5'h2);
    tick(30);
    chk("sleep pulses", pulse_cnt, c0);
    sleep_req <= 1'b1;
    @(posedge ref_clk);
    sleep_req <= 1'b0;
    @(posedge ref_clk);
    chk("abort", {31'h0, sleep_abort}, 32'h1);
    op_mode <= EFIU_MODE_STANDBY;
    tick(30);
    chk("standby", {31'h0, pulse_cnt > c0}, 32'h1);
    xfer(8'h08, 1'b1, 32'h7FF);
    live[0] <= 1'b1;
    tick(8);
    op_mode <= EFIU_MODE_RESET;
    tick(4);
    rd(8'h00, 32'h0);
    rd(8'h08, 32'h0);
    rd(8'h04, 32'h2);
    op_mode <= EFIU_MODE_STANDBY;
    xfer(8'h14, 1'b1, 32'h1);
    pulse_wake(5'h10);
    tick(4);
    rd(8'h04, 32'h10);
    xfer(8'h10, 1'b1, 32'h0);
    pulse_wake(5'h8);
    tick(4);
    rd(8'h04, 32'h0);
    // reset in mid-run: mode_wd back to default, no false pin edge after it
    live[0] <= 1'b0;
    arst_n <= 1'b0;
    tick(2);
    chk("rst oe", {31'h0, irq_oe}, 32'h0);
    arst_n <= 1'b1;
    tick(8);
    rd(8'h14, 32'h0);
    rd(8'h00, 32'h0);
    stop_test();
  end
endmodule
`default_nettype wire
